// File: common/dbs_pkg.sv
// Package with size codes, byte counts, reset values and states for the bus sizing unit.
// How it works
// - Both acknowledges negated: hold cycle, wait.
// - Narrow acknowledge only: 8-bit port, complete.
// - Wide acknowledge only: 16-bit port, complete.
// - Both acknowledges: complete as 16-bit port.
// - Start each cycle assuming a 16-bit port.
// - Byte 0 is the most significant byte.
// - Size code gives bytes still remaining.
// - Address 31-1 word base, bit 0 byte.
// - Odd byte to wide port uses low lane.
// - Reads ignore the duplicate or unused lane.
// - Second long-word byte cycle uses three-byte code.
// - Long word: two wide or four narrow cycles.
// - One aligned word per cycle, high word first.
// - Byte aligned anywhere; odd word is misaligned.
// - Misaligned request raises address error, no cycle.
// - Size codes: 01 byte, 10 word, 11 three, 00 long.
package dbs_pkg;
	// Size codes on the size outputs.
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_THREE = 2'h3;
	localparam logic [1:0] SIZE_LONG = 2'h0;
	// Remaining-byte counts per operand size.
	localparam logic [2:0] COUNT_BYTE = 3'h1;
	localparam logic [2:0] COUNT_WORD = 3'h2;
	localparam logic [2:0] COUNT_LONG = 3'h4;
	// Reset values.
	localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
	localparam logic [31:0] RESET_DATA = 32'h0000_0000;
	// Controller states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CYCLE = 2'b01,
		ST_DONE = 2'b10
	} state_e;
endpackage : dbs_pkg

// File: hw/dbs_lane_mux.sv
// Byte-lane multiplexer that places write bytes and picks read bytes.
`timescale 1ns/1ns
module dbs_lane_mux (
	// Operand and cycle position.
	input wire logic [31:0] operand,
	input wire logic [2:0] remaining,
	input wire logic addr_bit0,
	// Bus side data.
	input wire logic [15:0] bus_in,
	input wire logic wide,
	// Lane results.
	output logic [15:0] bus_out,
	output logic [7:0] read_hi_byte,
	output logic [7:0] read_lo_byte,
	output logic take_two
);
	// Index of the leading byte still to move, counted from byte 0.
	logic [1:0] lead;
	logic [7:0] lead_byte;
	logic [7:0] next_byte;

	// Select the leading byte and its follower from the operand.
	always_comb begin
		lead = 2'(3'h4 - remaining);
		lead_byte = operand[8'(31 - 8 * lead) -: 8];
		next_byte = (lead == 2'h3) ? lead_byte : operand[8'(23 - 8 * lead) -: 8];
		// A lone byte is duplicated on both lanes; otherwise leading byte high.
		if (remaining == 3'h1 || remaining == 3'h3) begin
			bus_out = {lead_byte, lead_byte};
		end else begin
			bus_out = {lead_byte, next_byte};
		end
		// Odd single byte from a wide port arrives on the low lane.
		if (wide && addr_bit0) begin
			read_hi_byte = bus_in[7:0];
		end else begin
			read_hi_byte = bus_in[15:8];
		end
		read_lo_byte = bus_in[7:0];
		// Only an even wide cycle with two or four bytes left takes both lanes.
		take_two = wide && !addr_bit0 && (remaining == 3'h2 || remaining == 3'h4);
	end
endmodule : dbs_lane_mux

// File: hw/dynamic_bus_sizing_unit.sv
// Bus master that splits byte, word and long-word operands over 8/16-bit ports.
`timescale 1ns/1ns
module dynamic_bus_sizing_unit (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Operand request from the processor.
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [1:0] req_size,
	input wire logic [31:0] req_addr,
	input wire logic [31:0] req_wdata,
	output logic req_ready,
	output logic done,
	output logic [31:0] rdata,
	output logic addr_error,
	// External bus.
	output logic cycle_active,
	output logic bus_write,
	output logic [31:0] bus_addr,
	output logic size_code_hi,
	output logic size_code_lo,
	output logic [15:0] data_out,
	output logic data_oe,
	input wire logic [15:0] data_in,
	input wire logic ack_wide_port,
	input wire logic ack_narrow_port
);
	// Registered controller state.
	dbs_pkg::state_e state;
	dbs_pkg::state_e next_state;
	logic [31:0] addr;
	logic [31:0] next_addr;
	logic [31:0] operand;
	logic [31:0] next_operand;
	logic [2:0] remaining;
	logic [2:0] next_remaining;
	logic [2:0] total;
	logic [2:0] next_total;
	logic write;
	logic next_write;
	logic err;
	logic next_err;
	// Decoded helpers.
	logic any_ack;
	logic wide;
	logic [1:0] size_now;
	logic [2:0] moved;
	logic [2:0] req_count;
	logic [15:0] lane_out;
	logic [7:0] rd_hi;
	logic [7:0] rd_lo;
	logic take_two;

	// Acknowledge decode: any acknowledge ends the cycle; wide wins if both.
	assign any_ack = ack_wide_port | ack_narrow_port;
	assign wide = ack_wide_port;

	// The lane mux sees the current cycle and the port width just reported.
	dbs_lane_mux dbs_lane_mux_inst (
		.operand(operand),
		.remaining(remaining),
		.addr_bit0(addr[0]),
		.bus_in(data_in),
		.wide(wide),
		.bus_out(lane_out),
		.read_hi_byte(rd_hi),
		.read_lo_byte(rd_lo),
		.take_two(take_two)
	);

	// Size code is the count still to move, not what this cycle carries.
	always_comb begin
		case (remaining)
			3'h1: size_now = dbs_pkg::SIZE_BYTE;
			3'h2: size_now = dbs_pkg::SIZE_WORD;
			3'h3: size_now = dbs_pkg::SIZE_THREE;
			default: size_now = dbs_pkg::SIZE_LONG;
		endcase
	end

	// Count requested by the operand size.
	always_comb begin
		case (req_size)
			dbs_pkg::SIZE_BYTE: req_count = dbs_pkg::COUNT_BYTE;
			dbs_pkg::SIZE_WORD: req_count = dbs_pkg::COUNT_WORD;
			default: req_count = dbs_pkg::COUNT_LONG;
		endcase
	end

	// Bytes moved this cycle: two only from a wide port on an even word.
	assign moved = take_two ? 3'h2 : 3'h1;

	// Next-state logic for the operand sequencer.
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_operand = operand;
		next_remaining = remaining;
		next_total = total;
		next_write = write;
		next_err = 1'b0;
		case (state)
			dbs_pkg::ST_IDLE: begin
				if (req_valid) begin
					// Odd word or long word never reaches the bus.
					if (req_count != dbs_pkg::COUNT_BYTE && req_addr[0]) begin
						next_err = 1'b1;
					end else begin
						next_state = dbs_pkg::ST_CYCLE;
						next_addr = req_addr;
						next_remaining = req_count;
						next_total = req_count;
						next_write = req_write;
						// Writes stay right-justified, because the lane mux finds byte 0
						// from the remaining count; shifting here would send zero bytes.
						next_operand = req_write ? req_wdata : dbs_pkg::RESET_DATA;
					end
				end
			end
			dbs_pkg::ST_CYCLE: begin
				// Without an acknowledge the cycle simply stays open.
				if (any_ack) begin
					if (!write) begin
						// Latch only the valid bytes, shifting them in at the bottom.
						if (take_two) begin
							next_operand = {operand[15:0], rd_hi, rd_lo};
						end else begin
							next_operand = {operand[23:0], rd_hi};
						end
					end
					next_remaining = remaining - moved;
					next_addr = addr + {29'h0, moved};
					if (remaining == moved) begin
						next_state = dbs_pkg::ST_DONE;
					end
				end
			end
			default: begin
				next_state = dbs_pkg::ST_IDLE;
			end
		endcase
	end

	// Register the sequencer state.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= dbs_pkg::ST_IDLE;
			addr <= dbs_pkg::RESET_ADDR;
			operand <= dbs_pkg::RESET_DATA;
			remaining <= 3'h0;
			total <= 3'h0;
			write <= 1'b0;
			err <= 1'b0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			operand <= next_operand;
			remaining <= next_remaining;
			total <= next_total;
			write <= next_write;
			err <= next_err;
		end
	end

	// Outputs; data bus is driven on every byte lane during writes.
	assign req_ready = (state == dbs_pkg::ST_IDLE);
	assign done = (state == dbs_pkg::ST_DONE);
	assign addr_error = err;
	assign cycle_active = (state == dbs_pkg::ST_CYCLE);
	assign bus_write = write;
	assign bus_addr = addr;
	assign size_code_hi = size_now[1];
	assign size_code_lo = size_now[0];
	assign data_out = lane_out;
	assign data_oe = cycle_active && write;

	// Read data right-justified; writes return zero.
	always_comb begin
		if (write) begin
			rdata = dbs_pkg::RESET_DATA;
		end else begin
			rdata = operand;
		end
	end

	// Assertions.
	sequence s_open_no_ack;
		cycle_active && !any_ack;
	endsequence

	sequence s_long_wide_first;
		cycle_active && remaining == 3'h4 && ack_wide_port && !addr[0];
	endsequence

	AST_WAIT_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
		s_open_no_ack |=> cycle_active && $stable(addr) && $stable(remaining))
		else $error("Cycle did not hold while unacknowledged.");
	AST_NARROW_ONE: assert property (@(posedge sys_clk) disable iff (rst)
		cycle_active && ack_narrow_port && !ack_wide_port |=>
		remaining == $past(remaining) - 3'h1 || done)
		else $error("Narrow acknowledge moved other than one byte.");
	AST_WIDE_EVEN_TWO: assert property (@(posedge sys_clk) disable iff (rst)
		s_long_wide_first |=> remaining == 3'h2 && addr == $past(addr) + 32'h2)
		else $error("Wide long-word first cycle did not move two bytes.");
	AST_BOTH_AS_WIDE: assert property (@(posedge sys_clk) disable iff (rst)
		cycle_active && ack_wide_port && ack_narrow_port && !addr[0]
		&& (remaining == 3'h2 || remaining == 3'h4)
		|=> remaining == $past(remaining) - 3'h2)
		else $error("Both acknowledges not treated as wide port.");
	AST_SIZE_REMAIN: assert property (@(posedge sys_clk) disable iff (rst)
		cycle_active && remaining == 3'h3 |-> size_code_hi && size_code_lo)
		else $error("Three bytes left but size code not three.");
	AST_ODD_ERROR: assert property (@(posedge sys_clk) disable iff (rst)
		req_ready && req_valid && req_addr[0] && req_size != dbs_pkg::SIZE_BYTE
		|=> addr_error && !cycle_active)
		else $error("Odd word request did not raise address error.");
	AST_LONG_NARROW_FOUR: assert property (@(posedge sys_clk) disable iff (rst)
		cycle_active && remaining == 3'h4 && ack_narrow_port && !ack_wide_port
		|=> remaining == 3'h3 && addr[0])
		else $error("Long word to narrow port did not step one byte.");
	AST_ODD_LOW_LANE: assert property (@(posedge sys_clk) disable iff (rst)
		cycle_active && ack_wide_port && addr[0] |-> rd_hi == data_in[7:0])
		else $error("Odd byte from wide port not taken from low lane.");
	AST_NEVER_OVER_WORD: assert property (@(posedge sys_clk) disable iff (rst)
		cycle_active && any_ack |=> ($past(remaining) - remaining) <= 3'h2
		|| done)
		else $error("More than one word moved in one cycle.");
endmodule : dynamic_bus_sizing_unit

// File: verif/dbs_slave_model.sv
// Behavioural 8-bit or 16-bit slave that answers the bus sizing unit.
`timescale 1ns/1ns
module dbs_slave_model (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Bus from the master.
	input wire logic cycle_active,
	input wire logic bus_write,
	input wire logic [31:0] bus_addr,
	input wire logic [1:0] size_code,
	input wire logic [15:0] data_out,
	// Port mode (0 narrow, 1 wide, 2 both acknowledges) and wait states.
	input wire logic [1:0] mode,
	input wire logic [3:0] waits,
	// Answer to the master.
	output logic [15:0] data_in,
	output logic ack_wide_port,
	output logic ack_narrow_port
);
	logic [7:0] mem [16]; // Byte store indexed by the low address bits.
	logic [3:0] cnt; // Wait states inserted so far.
	logic ack; // Acknowledge of either kind.
	logic [3:0] a; // Byte index of this cycle.
	logic [15:0] rd; // Read lanes before the junk mask.
	assign a = bus_addr[3:0];
	// The slave always reports its own width, whatever the transfer size.
	assign ack_wide_port = ack && mode != 2'h0;
	assign ack_narrow_port = ack && mode != 2'h1;
	// A narrow port owns 15-8 only, so its low lane carries junk.
	assign rd = (mode != 2'h0) ? {mem[{a[3:1], 1'b0}], mem[{a[3:1], 1'b1}]} : {mem[a], ~mem[a]};
	// Lanes are inverted outside the acked edge, so early sampling is caught.
	assign data_in = ack ? rd : ~rd;
	// Count wait states, acknowledge for one edge, then store the written lanes.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			ack <= 1'b0;
		end else if (ack) begin
			ack <= 1'b0;
			cnt <= 4'h0;
			if (bus_write && mode == 2'h0) begin
				mem[a] <= data_out[15:8];
			end else if (bus_write && (a[0] || size_code == 2'h1)) begin
				mem[a] <= a[0] ? data_out[7:0] : data_out[15:8];
			end else if (bus_write) begin
				mem[a] <= data_out[15:8];
				mem[a + 4'h1] <= data_out[7:0];
			end
		end else if (cycle_active) begin
			// Without an acknowledge the cycle stays open.
			ack <= (cnt == waits);
			cnt <= cnt + 4'h1;
		end
	end
endmodule : dbs_slave_model

// File: verif/dynamic_bus_sizing_unit_test.sv
// Self-checking bench for the bus sizing unit against the slave model.
`timescale 1ns/1ns
module dynamic_bus_sizing_unit_test;
	logic sys_clk = 1'b0; // System clock, 40 ns period.
	logic rst = 1'b1; // Reset, held for two cycles.
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [1:0] req_size = 2'h0;
	logic [31:0] req_addr = 32'h0;
	logic [31:0] req_wdata = 32'h0;
	logic [1:0] mode = 2'h0; // Slave port mode.
	logic [3:0] waits = 4'h0; // Slave wait states.
	logic req_ready, done, addr_error, cycle_active, bus_write, size_code_hi, size_code_lo;
	logic data_oe, ack_wide_port, ack_narrow_port;
	logic [31:0] rdata, bus_addr;
	logic [15:0] data_out, data_in;
	logic [1:0] szq [$]; // Size codes of acked cycles.
	logic [31:0] adq [$]; // Addresses of acked cycles.
	int error_cnt = 0;
	int checks_done = 0;
	dynamic_bus_sizing_unit dynamic_bus_sizing_unit_inst (.sys_clk, .rst, .req_valid, .req_write,
		.req_size, .req_addr, .req_wdata, .req_ready, .done, .rdata, .addr_error, .cycle_active,
		.bus_write, .bus_addr, .size_code_hi, .size_code_lo, .data_out, .data_oe, .data_in,
		.ack_wide_port, .ack_narrow_port);
	dbs_slave_model dbs_slave_model_inst (.sys_clk, .rst, .cycle_active, .bus_write, .bus_addr,
		.size_code({size_code_hi, size_code_lo}), .data_out, .mode, .waits, .data_in,
		.ack_wide_port, .ack_narrow_port);
	// Free-running clock.
	initial forever #20 sys_clk = ~sys_clk;
	// Log every acknowledged bus cycle for later comparison.
	always @(posedge sys_clk) begin
		if (cycle_active && (ack_wide_port || ack_narrow_port)) begin
			szq.push_back({size_code_hi, size_code_lo});
			adq.push_back(bus_addr);
			check({bus_write, data_oe, req_ready}, {req_write, req_write, 1'b0});
		end
	end
	// Compare one value and count it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	// Issue one operand and wait, bounded, for done or an address error.
	task automatic op(input logic w, input logic [1:0] sz, input logic [31:0] ad, dat);
		int n;
		n = 0;
		szq.delete();
		adq.delete();
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_size <= sz;
		req_addr <= ad;
		req_wdata <= dat;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		#1;
		while (done !== 1'b1 && addr_error !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check(done || addr_error, 1'b1);
	endtask : op
	// Check cycle count, size code sequence (two bits per cycle) and address steps.
	task automatic cyc(input int n, input logic [7:0] codes, input int step);
		check(szq.size(), n);
		foreach (szq[i]) begin
			check(szq[i], codes[2*i+:2]);
			check(adq[i], req_addr + step * i);
		end
	endtask : cyc
	// Long word through an 8-bit port with wait states, written then read.
	task automatic t_long_narrow;
		mode = 2'h0;
		waits = 4'h2;
		op(1'b1, 2'h0, 32'h4, 32'h1122_3344);
		cyc(4, 8'h6c, 1);
		op(1'b0, 2'h0, 32'h4, 32'h0);
		cyc(4, 8'h6c, 1);
		check(rdata, 32'h1122_3344);
	endtask : t_long_narrow
	// Long word through a 16-bit port, then read back over the 8-bit port.
	task automatic t_long_wide;
		mode = 2'h1;
		waits = 4'h0;
		op(1'b1, 2'h0, 32'h8, 32'h5566_7788);
		cyc(2, 8'h08, 2);
		op(1'b0, 2'h0, 32'h8, 32'h0);
		check(rdata, 32'h5566_7788);
		mode = 2'h0;
		op(1'b0, 2'h0, 32'h8, 32'h0);
		check(rdata, 32'h5566_7788);
	endtask : t_long_wide
	// Odd and even bytes on a 16-bit port, odd byte again over the 8-bit port.
	task automatic t_bytes;
		mode = 2'h1;
		op(1'b1, 2'h1, 32'h3, 32'ha5);
		cyc(1, 8'h01, 1);
		op(1'b1, 2'h1, 32'h2, 32'h5a);
		op(1'b0, 2'h1, 32'h3, 32'h0);
		check(rdata, 32'ha5);
		op(1'b0, 2'h1, 32'h2, 32'h0);
		check(rdata, 32'h5a);
		mode = 2'h0;
		op(1'b0, 2'h1, 32'h3, 32'h0);
		check(rdata, 32'ha5);
	endtask : t_bytes
	// Word with both acknowledges, read back in two narrow cycles.
	task automatic t_word;
		mode = 2'h2;
		op(1'b1, 2'h2, 32'hc, 32'hbeef);
		cyc(1, 8'h02, 2);
		mode = 2'h0;
		op(1'b0, 2'h2, 32'hc, 32'h0);
		cyc(2, 8'h06, 1);
		check(rdata, 32'hbeef);
	endtask : t_word
	// Odd word and long requests raise an address error and run no cycle.
	task automatic t_misalign;
		mode = 2'h1;
		op(1'b0, 2'h2, 32'h5, 32'h0);
		check(addr_error, 1'b1);
		check(szq.size(), 0);
		op(1'b1, 2'h0, 32'h7, 32'h0);
		check(addr_error, 1'b1);
		check(szq.size(), 0);
	endtask : t_misalign
	// Print the counts and the verdict, then end the run.
	task automatic stop_test;
		$display("checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	// Main sequence.
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		t_long_narrow();
		t_long_wide();
		t_bytes();
		t_word();
		t_misalign();
		stop_test();
	end
	// Watchdog, well beyond the hundred or so cycles the tests need.
	initial begin
		#(40 * 4000);
		error_cnt++;
		stop_test();
	end
endmodule : dynamic_bus_sizing_unit_test
